// ==== verilog/pes_status_bank.v ====
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
`include "pes_defs.vh"

module pes_status_bank (
  // clock and reset
  input  wire        sys_clk,
  input  wire        srst,
  // register port
  input  wire [15:0] reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // per-phase detector inputs (bit 0 = phase a) and the shared half cycle tick
  input  wire [2:0]  overcurrent_hit,
  input  wire [2:0]  overvoltage_hit,
  input  wire [2:0]  below_dip_level,
  input  wire        half_cycle_tick,
  input  wire [2:0]  total_noload_cond,
  input  wire [2:0]  fundamental_noload_cond,
  input  wire [2:0]  apparent_noload_cond,
  // interrupt
  output reg         irq
);

  // per-phase and shared register state
  reg  [2:0]  overcurrent_phase_bits;
  reg  [2:0]  overvoltage_phase_bits;
  reg  [2:0]  dip_state_bits;
  reg  [2:0]  total_power_noload_bits;
  reg  [2:0]  fundamental_noload_bits;
  reg  [2:0]  apparent_noload_bits;
  reg  [7:0]  dip_half_cycle_count;
  reg  [7:0]  dip_cnt [0:2];
  reg  [31:0] main_interrupt_status;
  reg  [31:0] main_interrupt_mask;
  reg  [2:0]  next_dip_state;
  reg  [2:0]  dip_flip;
  reg  [31:0] ev_set;
  reg  [31:0] next_rdata;
  wire [15:0] phase_event_status;
  wire [15:0] phase_noload_status;
  wire        wr_status;
  wire        wr_mask;
  wire        wr_cycles;
  integer     i;
  integer     j;

  // word decode shared by read and write paths
  function hit;
    input [15:0] a;
    input [15:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  assign wr_status = reg_wr & hit(reg_addr, `PES_ADDR_MAIN_STATUS);
  assign wr_mask   = reg_wr & hit(reg_addr, `PES_ADDR_MAIN_MASK);
  assign wr_cycles = reg_wr & hit(reg_addr, `PES_ADDR_DIP_CYCLES);

  // register images; unused bits are hard zero
  assign phase_event_status  = {1'b0, dip_state_bits, overvoltage_phase_bits,
                                3'b000, overcurrent_phase_bits, 3'b000};
  assign phase_noload_status = {7'h00, apparent_noload_bits,
                                fundamental_noload_bits, total_power_noload_bits};

  // dip qualification: a level must persist for the programmed half cycles
  always @* begin
    next_dip_state = dip_state_bits;
    for (i = 0; i < 3; i = i + 1) begin
      if (below_dip_level[i] != dip_state_bits[i] && half_cycle_tick &&
          dip_cnt[i] + 8'h01 >= dip_half_cycle_count) begin
        next_dip_state[i] = below_dip_level[i];
      end
    end
    dip_flip = next_dip_state ^ dip_state_bits;
  end

  // events raised into the main status this cycle
  always @* begin
    ev_set = 32'h0000_0000;
    ev_set[`PES_ST_OC]       = |overcurrent_hit;
    ev_set[`PES_ST_OV]       = |overvoltage_hit;
    ev_set[`PES_ST_DIP]      = |dip_flip;
    ev_set[`PES_ST_NL_TOTAL] = |(total_noload_cond & ~total_power_noload_bits);
    ev_set[`PES_ST_NL_FUND]  = |(fundamental_noload_cond & ~fundamental_noload_bits);
    ev_set[`PES_ST_NL_APP]   = |(apparent_noload_cond & ~apparent_noload_bits);
  end

  // per-phase bits: set by hardware; a main status write clears the overcurrent and overvoltage ones
  always @(posedge sys_clk) begin
    if (srst) begin
      overcurrent_phase_bits  <= 3'h0;
      overvoltage_phase_bits  <= 3'h0;
      dip_state_bits          <= 3'h0;
      total_power_noload_bits <= 3'h0;
      fundamental_noload_bits <= 3'h0;
      apparent_noload_bits    <= 3'h0;
      for (j = 0; j < 3; j = j + 1) begin
        dip_cnt[j] <= 8'h00;
      end
    end else begin
      // phase source bits are rearmed when software clears the main flag
      if (wr_status && reg_wdata[`PES_ST_OC]) begin
        overcurrent_phase_bits <= overcurrent_hit;
      end else begin
        overcurrent_phase_bits <= overcurrent_phase_bits | overcurrent_hit;
      end
      if (wr_status && reg_wdata[`PES_ST_OV]) begin
        overvoltage_phase_bits <= overvoltage_hit;
      end else begin
        overvoltage_phase_bits <= overvoltage_phase_bits | overvoltage_hit;
      end
      dip_state_bits          <= next_dip_state;
      total_power_noload_bits <= total_noload_cond;
      fundamental_noload_bits <= fundamental_noload_cond;
      apparent_noload_bits    <= apparent_noload_cond;
      // counter restarts whenever the level agrees with the state
      for (j = 0; j < 3; j = j + 1) begin
        if (below_dip_level[j] == dip_state_bits[j] || dip_flip[j]) begin
          dip_cnt[j] <= 8'h00;
        end else if (half_cycle_tick && dip_cnt[j] != 8'hff) begin
          dip_cnt[j] <= dip_cnt[j] + 8'h01;
        end
      end
    end
  end

  // main status: write one to clear, a new event wins over the clear
  always @(posedge sys_clk) begin
    if (srst) begin
      main_interrupt_status <= `PES_RST_MAIN32;
      main_interrupt_mask   <= `PES_RST_MAIN32;
      dip_half_cycle_count  <= `PES_RST_DIP_CYCLES;
    end else begin
      main_interrupt_status <= (main_interrupt_status & ~(wr_status ? reg_wdata : 32'h0))
                               | ev_set;
      if (wr_mask) begin
        main_interrupt_mask <= reg_wdata;
      end
      if (wr_cycles) begin
        dip_half_cycle_count <= reg_wdata[7:0];
      end
    end
  end

  // read mux; writes to the two status words fall through unused
  always @* begin
    if (hit(reg_addr, `PES_ADDR_PHASE_EVENT)) begin
      next_rdata = {16'h0000, phase_event_status};
    end else if (hit(reg_addr, `PES_ADDR_PHASE_NOLOAD)) begin
      next_rdata = {16'h0000, phase_noload_status};
    end else if (hit(reg_addr, `PES_ADDR_MAIN_STATUS)) begin
      next_rdata = main_interrupt_status;
    end else if (hit(reg_addr, `PES_ADDR_MAIN_MASK)) begin
      next_rdata = main_interrupt_mask;
    end else if (hit(reg_addr, `PES_ADDR_DIP_CYCLES)) begin
      next_rdata = {24'h000000, dip_half_cycle_count};
    end else begin
      next_rdata = 32'h0000_0000; // unmapped reads zero
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= 32'h0000_0000;
      irq       <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
      // one cycle of latency on irq keeps the output straight from a flop
      irq       <= |(main_interrupt_status & main_interrupt_mask);
    end
  end

endmodule // pes_status_bank

// ==== verilog/pes_defs.vh ====
`ifndef PES_DEFS_VH
`define PES_DEFS_VH

// register offsets (16-bit address space)
`define PES_ADDR_PHASE_EVENT    16'he600
`define PES_ADDR_PHASE_NOLOAD   16'he608
`define PES_ADDR_MAIN_STATUS    16'he602
`define PES_ADDR_MAIN_MASK      16'he604
`define PES_ADDR_DIP_CYCLES     16'he606

// phase event field positions (low bit of each 3-bit group)
`define PES_EV_OC_LSB           3
`define PES_EV_OV_LSB           9
`define PES_EV_DIP_LSB          12
// no-load field positions
`define PES_NL_TOTAL_LSB        0
`define PES_NL_FUND_LSB         3
`define PES_NL_APP_LSB          6
// main status bit positions
`define PES_ST_NL_TOTAL         0
`define PES_ST_NL_FUND          1
`define PES_ST_NL_APP           2
`define PES_ST_DIP              16
`define PES_ST_OC               17
`define PES_ST_OV               18

// reset values
`define PES_RST_STATUS16        16'h0000
`define PES_RST_MAIN32          32'h0000_0000
`define PES_RST_DIP_CYCLES      8'h03

`endif

// ==== verification/pes_host_model.sv ====
`timescale 1ns/1ns
module pes_host_model (
  // clock
  input  logic        sys_clk,
  // register port, driven as bus master
  output logic [15:0] reg_addr = 16'h0,
  output logic [31:0] reg_wdata = 32'h0,
  output logic        reg_wr = 1'h0,
  output logic        reg_rd = 1'h0,
  input  logic [31:0] reg_rdata
);
  // one write cycle; data inverted after so a stale bus never looks valid
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
    reg_wdata <= ~d;
  endtask
  // one read cycle; data stands only in the following cycle
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1;
    d = reg_rdata;
  endtask
endmodule // pes_host_model

// ==== verification/pes_status_monitor.sv ====
`timescale 1ns/1ns
module pes_status_monitor (
  // clock, reset and register port
  input logic        sys_clk,
  input logic        srst,
  input logic [15:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [31:0] reg_rdata,
  // detectors and interrupt
  input logic [2:0]  overcurrent_hit,
  input logic [2:0]  overvoltage_hit,
  input logic [2:0]  below_dip_level,
  input logic        half_cycle_tick,
  input logic [2:0]  total_noload_cond,
  input logic [2:0]  fundamental_noload_cond,
  input logic [2:0]  apparent_noload_cond,
  input logic        irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // settled is low on the edge after reset, when status still holds reset zeros
  logic settled = 1'h0;
  always_ff @(posedge sys_clk) settled <= !srst;
  wire ev_rd = reg_rd && reg_addr == 16'he600;
  wire nl_rd = reg_rd && reg_addr == 16'he608 && settled;
  a_event_rsvd: assert property (ev_rd |=>
    (reg_rdata & 32'hffff_81c7) == 32'h0) else $error("event reserved bits set");
  a_noload_rsvd: assert property (nl_rd |=>
    (reg_rdata & 32'hffff_fe00) == 32'h0) else $error("no-load reserved bits set");
  a_oc_phase: assert property (overcurrent_hit[1] ##1 ev_rd |=> reg_rdata[4])
    else $error("overcurrent phase b missing");
  a_ov_phase: assert property (overvoltage_hit[2] ##1 ev_rd |=> reg_rdata[11])
    else $error("overvoltage phase c missing");
  a_total_noload: assert property (nl_rd && $stable(total_noload_cond) |=>
    reg_rdata[2:0] == $past(total_noload_cond, 2)) else $error("total no-load bits");
  a_other_noload: assert property (nl_rd && $stable({apparent_noload_cond,
    fundamental_noload_cond}) |=> reg_rdata[8:3] == $past({apparent_noload_cond,
    fundamental_noload_cond}, 2)) else $error("fundamental or apparent no-load bits");
  a_dip_hold: assert property (ev_rd && !half_cycle_tick ##1 !half_cycle_tick
    ##1 ev_rd |=> reg_rdata[14:12] == $past(reg_rdata[14:12], 2))
    else $error("dip state moved without a tick");
  a_reset_clear: assert property (disable iff (1'h0) srst |=>
    reg_rdata == 32'h0 && !irq) else $error("reset did not clear outputs");
  // main scenarios reached
  c_oc_seen: cover property (ev_rd ##1 reg_rdata[4]);
  c_noload_seen: cover property (nl_rd ##1 reg_rdata[8:0] != 9'h0);
  c_irq_seen: cover property ($rose(irq));
endmodule // pes_status_monitor

bind pes_status_bank pes_status_monitor u_mon (.*);

// ==== verification/pes_status_bank_bench.sv ====
`timescale 1ns/1ns
module pes_status_bank_bench;
  logic       sys_clk = 1'h0;
  logic       srst = 1'h1;
  logic       half_cycle_tick = 1'h0;
  logic [2:0] overcurrent_hit = 3'h0, overvoltage_hit = 3'h0, below_dip_level = 3'h0;
  logic [2:0] total_noload_cond = 3'h0, fundamental_noload_cond = 3'h0;
  logic [2:0] apparent_noload_cond = 3'h0;
  wire [15:0] reg_addr;
  wire [31:0] reg_wdata, reg_rdata;
  wire        reg_wr, reg_rd, irq;
  int         n_mismatch = 0, checked = 0;
  // 50 MHz system clock
  always #10 sys_clk = ~sys_clk;
  pes_host_model host (.*);
  pes_status_bank DUT (.*);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] v;
    host.rd(a, v);
    chk(v, exp);
  endtask
  // half line cycle ticks, one cycle wide and two cycles apart
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge sys_clk) half_cycle_tick <= 1'h1;
      @(posedge sys_clk) half_cycle_tick <= 1'h0;
    end
  endtask
  task automatic finish_test;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // a hang is cut short well inside the cycle budget
  initial begin
    #200000;
    n_mismatch++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    srst <= 1'h0;
    host.wr(16'he600, 32'hffff_ffff);
    host.wr(16'he608, 32'hffff_ffff);
    rc(16'he600, 32'h0);
    rc(16'he608, 32'h0);
    // dip on phase a with a count of two half cycles
    host.wr(16'he606, 32'h2);
    below_dip_level <= 3'h1;
    ticks(1);
    rc(16'he600, 32'h0);
    ticks(1);
    rc(16'he600, 32'h1000);
    rc(16'he600, 32'h1000);
    rc(16'he602, 32'h1_0000);
    host.wr(16'he602, 32'h1_0000);
    below_dip_level <= 3'h0;
    ticks(2);
    rc(16'he600, 32'h0);
    rc(16'he602, 32'h1_0000);
    host.wr(16'he602, 32'h1_0000);
    // overcurrent on phase b: masked, unmasked, then cleared
    @(posedge sys_clk) overcurrent_hit <= 3'h2;
    @(posedge sys_clk) overcurrent_hit <= 3'h0;
    rc(16'he600, 32'h10);
    chk({31'h0, irq}, 32'h0);
    host.wr(16'he604, 32'h2_0000);
    repeat (2) @(posedge sys_clk);
    #1 chk({31'h0, irq}, 32'h1);
    host.wr(16'he602, 32'h2_0000);
    repeat (2) @(posedge sys_clk);
    #1 chk({31'h0, irq}, 32'h0);
    rc(16'he600, 32'h0);
    @(posedge sys_clk) overvoltage_hit <= 3'h4;
    @(posedge sys_clk) overvoltage_hit <= 3'h0;
    rc(16'he600, 32'h800);
    // mixed no-load conditions, then all out of no load
    @(posedge sys_clk) {apparent_noload_cond, fundamental_noload_cond, total_noload_cond} <= 9'h1d5;
    rc(16'he608, 32'h1d5);
    rc(16'he602, 32'h4_0007);
    @(posedge sys_clk) {apparent_noload_cond, fundamental_noload_cond, total_noload_cond} <= 9'h0;
    rc(16'he608, 32'h0);
    finish_test;
  end
endmodule // pes_status_bank_bench
